// file: hdl/ddsl_pkg.sv
// constants for the dual converter serial load front end
// assumes a single 25 MHz system clock samples every pin
package ddsl_pkg;
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned CNT_W      = 5;
	localparam int unsigned DAC_W      = 16;
	localparam logic [4:0]  LAST_CNT   = 5'h18;
	localparam logic [15:0] ZERO_CODE  = 16'h0000;
	localparam int unsigned ADDR_HI    = 17;
	localparam int unsigned ADDR_LO    = 16;
	localparam logic [1:0]  ADDR_A     = 2'h0;
	localparam logic [1:0]  ADDR_B     = 2'h1;
	localparam logic [1:0]  ADDR_ALL   = 2'h3;
	localparam int unsigned SYNC_W     = 5;
	localparam logic [4:0]  SYNC_RST   = 5'h1E;
	localparam int unsigned SCLK_BIT   = 0;
	localparam int unsigned SEL_BIT    = 1;
	localparam int unsigned DIN_BIT    = 2;
	localparam int unsigned LOAD_BIT   = 3;
	localparam int unsigned CLR_BIT    = 4;
	typedef enum logic [1:0] {
		DDSL_IDLE,
		DDSL_SHIFT,
		DDSL_HOLD
	} ddsl_state_type;
endpackage : ddsl_pkg

// file: hdl/ddsl_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
module ddsl_sync #(
	parameter int unsigned      W   = 1,
	parameter logic [W-1:0]     RST = '0
) (
	input  wire logic           mclk_i,
	input  wire logic           arst_n_i,
	input  wire logic [W-1:0]   d_i,
	output logic      [W-1:0]   q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= RST;
			q_o      <= RST;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : ddsl_sync
`default_nettype wire

// file: hdl/ddsl_top.sv
// serial load and update logic of a dual 16-bit voltage output converter
// assumes the host serial clock is well below mclk_i/2 and all pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
module ddsl_top (
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        sclk_i,
	input  wire logic        sync_n_i,
	input  wire logic        din_i,
	input  wire logic        load_strobe_n_i,
	input  wire logic        async_clear_n_i,
	output logic      [15:0] analog_out_a_o,
	output logic      [15:0] analog_out_b_o,
	output logic      [15:0] input_a_o,
	output logic      [15:0] input_b_o,
	output logic             clear_mode_o,
	output logic             frame_done_o
);
	logic [ddsl_pkg::SYNC_W-1:0]     pins_s;
	logic                            sclk_prev_reg;
	logic                            sel_prev_reg;
	logic                            clr_prev_reg;
	logic                            sclk_fall;
	logic                            sel_fall;
	logic                            clr_fall;
	logic                            sel_low;
	logic                            load_low;
	logic                            clr_low;
	logic                            din_s;
	ddsl_pkg::ddsl_state_type        state_reg;
	ddsl_pkg::ddsl_state_type        state_next;
	logic [ddsl_pkg::CNT_W-1:0]      cnt_reg;
	logic [ddsl_pkg::FRAME_BITS-1:0] shift_reg;
	logic [ddsl_pkg::FRAME_BITS-1:0] shift_next;
	logic                            last_bit;
	logic [1:0]                      addr;
	logic                            wr_a;
	logic                            wr_b;
	logic                            load_go;

	// pins pass two flops before use
	ddsl_sync #(
		.W   (ddsl_pkg::SYNC_W),
		.RST (ddsl_pkg::SYNC_RST)
	) u_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.d_i      ({async_clear_n_i, load_strobe_n_i, din_i, sync_n_i, sclk_i}),
		.q_o      (pins_s)
	);

	assign sel_low  = !pins_s[ddsl_pkg::SEL_BIT];
	assign load_low = !pins_s[ddsl_pkg::LOAD_BIT];
	assign clr_low  = !pins_s[ddsl_pkg::CLR_BIT];
	assign din_s    = pins_s[ddsl_pkg::DIN_BIT];

	// edge detectors on the synchronised pins
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_prev_reg <= 1'b0;
			sel_prev_reg  <= 1'b1;
			clr_prev_reg  <= 1'b1;
		end else begin
			sclk_prev_reg <= pins_s[ddsl_pkg::SCLK_BIT];
			sel_prev_reg  <= pins_s[ddsl_pkg::SEL_BIT];
			clr_prev_reg  <= pins_s[ddsl_pkg::CLR_BIT];
		end
	end

	assign sclk_fall = sclk_prev_reg && !pins_s[ddsl_pkg::SCLK_BIT];
	assign sel_fall  = sel_prev_reg && sel_low;
	assign clr_fall  = clr_prev_reg && clr_low;

	assign shift_next = {shift_reg[ddsl_pkg::FRAME_BITS-2:0], din_s};
	assign last_bit   = (state_reg == ddsl_pkg::DDSL_SHIFT) && sclk_fall && sel_low
		&& (cnt_reg == ddsl_pkg::LAST_CNT - 5'h01) && !clr_fall;
	assign addr       = shift_next[ddsl_pkg::ADDR_HI:ddsl_pkg::ADDR_LO];
	assign wr_a       = last_bit && (addr == ddsl_pkg::ADDR_A || addr == ddsl_pkg::ADDR_ALL);
	assign wr_b       = last_bit && (addr == ddsl_pkg::ADDR_B || addr == ddsl_pkg::ADDR_ALL);
	assign load_go    = load_low && !clr_low;

	// frame sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ddsl_pkg::DDSL_IDLE: begin
				if (sel_fall) begin
					state_next = ddsl_pkg::DDSL_SHIFT;
				end
			end
			ddsl_pkg::DDSL_SHIFT: begin
				if (!sel_low || clr_fall) begin
					state_next = ddsl_pkg::DDSL_IDLE;
				end else if (last_bit) begin
					state_next = ddsl_pkg::DDSL_HOLD;
				end
			end
			ddsl_pkg::DDSL_HOLD: begin
				if (!sel_low) begin
					state_next = ddsl_pkg::DDSL_IDLE;
				end
			end
			default: begin
				state_next = ddsl_pkg::DDSL_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ddsl_pkg::DDSL_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// bit counter, held at zero outside a frame so stray clocks count nothing
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= '0;
		end else if (state_reg != ddsl_pkg::DDSL_SHIFT || !sel_low || clr_fall) begin
			cnt_reg <= '0;
		end else if (sclk_fall) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end

	// shift register, emptied as a frame opens so no stale bits survive
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_reg <= '0;
		end else if (state_reg == ddsl_pkg::DDSL_IDLE && sel_fall) begin
			shift_reg <= '0;
		end else if (state_reg == ddsl_pkg::DDSL_SHIFT && sel_low && sclk_fall && !clr_fall) begin
			shift_reg <= shift_next;
		end
	end

	// input register A, written by a complete frame, zeroed by clear
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			input_a_o <= ddsl_pkg::ZERO_CODE;
		end else if (clr_fall) begin
			input_a_o <= ddsl_pkg::ZERO_CODE;
		end else if (wr_a) begin
			input_a_o <= shift_next[ddsl_pkg::DAC_W-1:0];
		end
	end

	// input register B, written by a complete frame, zeroed by clear
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			input_b_o <= ddsl_pkg::ZERO_CODE;
		end else if (clr_fall) begin
			input_b_o <= ddsl_pkg::ZERO_CODE;
		end else if (wr_b) begin
			input_b_o <= shift_next[ddsl_pkg::DAC_W-1:0];
		end
	end

	// output register A follows input A while the load strobe is low and the clear pin is high
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			analog_out_a_o <= ddsl_pkg::ZERO_CODE;
		end else if (clr_fall) begin
			analog_out_a_o <= ddsl_pkg::ZERO_CODE;
		end else if (load_go) begin
			analog_out_a_o <= input_a_o;
		end
	end

	// output register B, updated in the same cycle as A
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			analog_out_b_o <= ddsl_pkg::ZERO_CODE;
		end else if (clr_fall) begin
			analog_out_b_o <= ddsl_pkg::ZERO_CODE;
		end else if (load_go) begin
			analog_out_b_o <= input_b_o;
		end
	end

	// frame completion pulse, raised with the input register write
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_done_o <= 1'b0;
		end else begin
			frame_done_o <= last_bit;
		end
	end

	// clear code mode; a clear in the cycle of a closing bit wins
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clear_mode_o <= 1'b0;
		end else if (clr_fall) begin
			clear_mode_o <= 1'b1;
		end else if (last_bit) begin
			clear_mode_o <= 1'b0;
		end
	end
endmodule : ddsl_top
`default_nettype wire

// file: test/ddsl_host_model.sv
// host serial port model, 8 mclk per serial bit
// assumes calls start at a rising mclk edge
`timescale 1ns/10ps
`default_nettype none
module ddsl_host_model (
	input  wire logic mclk_i,
	output var logic  sclk_o = 1'b1,
	output var logic  sync_n_o = 1'b1,
	output var logic  din_o = 1'b0
);
	// n bits of w msb first; n below 24 aborts
	task automatic send(input logic [23:0] w, input int n);
		sync_n_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
		for (int i = 23; i > 23 - n; i--) begin
			din_o <= w[i];
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b0;
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b1;
		end
		din_o <= ~din_o;
		repeat (4) @(posedge mclk_i);
		sync_n_o <= 1'b1;
		repeat (4) @(posedge mclk_i);
	endtask : send
	// n serial clocks with frame select high; none may shift
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			din_o <= ~din_o;
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b0;
			repeat (4) @(posedge mclk_i);
			sclk_o <= 1'b1;
		end
		repeat (4) @(posedge mclk_i);
	endtask : stray
endmodule : ddsl_host_model
`default_nettype wire

// file: test/ddsl_top_assertions.sv
// checker for the serial load front end
// bound to ddsl_top, sees only its ports
`timescale 1ns/10ps
`default_nettype none
module ddsl_top_assertions (
	input wire logic        mclk_i,
	input wire logic        arst_n_i,
	input wire logic        sync_n_i,
	input wire logic        load_strobe_n_i,
	input wire logic        async_clear_n_i,
	input wire logic [15:0] analog_out_a_o,
	input wire logic [15:0] analog_out_b_o,
	input wire logic [15:0] input_a_o,
	input wire logic [15:0] input_b_o,
	input wire logic        clear_mode_o,
	input wire logic        frame_done_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_load_on; (!load_strobe_n_i && async_clear_n_i)[*8]; endsequence
	sequence s_clr_low; (!async_clear_n_i)[*8]; endsequence
	sequence s_load_off; (load_strobe_n_i && async_clear_n_i)[*8]; endsequence
	sequence s_sel_idle; (sync_n_i && async_clear_n_i)[*8]; endsequence
	a_load_copy: assert property (s_load_on |->
		analog_out_a_o == $past(input_a_o) && analog_out_b_o == $past(input_b_o)) else $error("no copy");
	a_load_idle: assert property (s_load_off |->
		$stable(analog_out_a_o) && $stable(analog_out_b_o)) else $error("output moved");
	a_clr_block: assert property (s_clr_low |->
		$stable(analog_out_a_o) && $stable(analog_out_b_o)) else $error("load not ignored");
	a_clr_zero: assert property ($fell(async_clear_n_i) |-> ##[2:6] (clear_mode_o &&
		input_a_o == 16'h0000 && input_b_o == 16'h0000 &&
		analog_out_a_o == 16'h0000 && analog_out_b_o == 16'h0000)) else $error("no clear");
	a_mode_exit: assert property ($fell(clear_mode_o) |->
		($past(frame_done_o) || frame_done_o) or ##1 frame_done_o) else $error("mode left early");
	a_done_mode: assert property (frame_done_o |-> !clear_mode_o) else $error("mode kept");
	a_done_pulse: assert property (frame_done_o |=> !frame_done_o) else $error("long done");
	a_idle_quiet: assert property (s_sel_idle |->
		$stable(input_a_o) && $stable(input_b_o) && !frame_done_o) else $error("idle write");
endmodule : ddsl_top_assertions
bind ddsl_top ddsl_top_assertions u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.sync_n_i(sync_n_i), .load_strobe_n_i(load_strobe_n_i), .async_clear_n_i(async_clear_n_i),
	.analog_out_a_o(analog_out_a_o), .analog_out_b_o(analog_out_b_o), .input_a_o(input_a_o),
	.input_b_o(input_b_o), .clear_mode_o(clear_mode_o), .frame_done_o(frame_done_o));
`default_nettype wire

// file: test/ddsl_top_bench.sv
// self-checking bench for the serial load front end
// assumes the host model drives the serial pins
`timescale 1ns/10ps
`default_nettype none
module ddsl_top_bench;
	logic             mclk_i = 1'b0;
	logic             rst_n = 1'b0;
	logic             ld_n = 1'b1;
	logic             clr_n = 1'b1;
	wire logic        sclk, sync_n, din, mode, done;
	wire logic [15:0] oa, ob, ia, ib;
	int               failures = 0;
	int               comparisons = 0;
	int               dones = 0;
	ddsl_host_model host (.mclk_i(mclk_i), .sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
	ddsl_top uut (.mclk_i(mclk_i), .arst_n_i(rst_n), .sclk_i(sclk), .sync_n_i(sync_n),
		.din_i(din), .load_strobe_n_i(ld_n), .async_clear_n_i(clr_n), .analog_out_a_o(oa),
		.analog_out_b_o(ob), .input_a_o(ia), .input_b_o(ib), .clear_mode_o(mode),
		.frame_done_o(done));
	always @(negedge mclk_i) if (done === 1'b1) dones++;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [23:0] wd(input logic [1:0] a, input logic [15:0] c);
		return {6'h00, a, c};
	endfunction : wd
	task automatic close_out();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	task automatic hold_load();
		host.send(wd(ddsl_pkg::ADDR_A, 16'h1234), 24);
		host.send(wd(ddsl_pkg::ADDR_B, 16'hFFFF), 24);
		host.send(wd(2'h2, 16'hAAAA), 24);
		chk("ia", ia, 16'h1234);
		chk("ib", ib, 16'hFFFF);
		chk("oa", oa, 16'h0000);
		ld_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		ld_n <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("oa", oa, 16'h1234);
		chk("ob", ob, 16'hFFFF);
	endtask : hold_load
	task automatic abort_all();
		int d0;
		d0 = dones;
		host.send(wd(ddsl_pkg::ADDR_ALL, 16'h8001), 24);
		host.stray(5);
		host.send(wd(ddsl_pkg::ADDR_A, 16'h0F0F), 23);
		chk("ia", ia, 16'h8001);
		chk("ib", ib, 16'h8001);
		chk("dones", 16'(dones - d0), 16'h0001);
	endtask : abort_all
	task automatic clear_run();
		int d0;
		ld_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		chk("ob", ob, 16'h8001);
		d0 = dones;
		fork
			host.send(wd(ddsl_pkg::ADDR_A, 16'h7777), 24);
			begin
				repeat (60) @(posedge mclk_i);
				clr_n <= 1'b0;
			end
		join
		chk("ia", ia, 16'h0000);
		chk("oa", oa, 16'h0000);
		chk("mode", {15'h0000, mode}, 16'h0001);
		host.send(wd(ddsl_pkg::ADDR_A, 16'h5555), 24);
		chk("ia", ia, 16'h5555);
		chk("dones", 16'(dones - d0), 16'h0001);
		chk("oa", oa, 16'h0000);
		chk("mode", {15'h0000, mode}, 16'h0000);
		clr_n <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("oa", oa, 16'h5555);
	endtask : clear_run
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk_i);
		hold_load();
		abort_all();
		clear_run();
		close_out();
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		failures++;
		close_out();
	end
endmodule : ddsl_top_bench
`default_nettype wire
